// ---- design/qpcd_pkg.sv ----
`default_nettype none
package qpcd_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int          CMD_BITS  = 24;
  localparam int          CNT_W     = 5;
  localparam logic [4:0]  CNT_MAX   = 5'h1f;
  localparam logic [4:0]  CNT_FRAME = 5'h18;
  localparam int          OPC_LSB   = 20;
  localparam int          SLOT_LSB  = 18;
  localparam int          CHAN_LSB  = 16;
  localparam int          DATA_W    = 9;
  localparam int          TAP_W     = 8;
  localparam int          NCHAN     = 4;
  localparam int          NSLOT     = 16;

  localparam logic [7:0]  TAP_MIN     = 8'h00;
  localparam logic [7:0]  TAP_MAX     = 8'hff;
  localparam logic [8:0]  SLOT_ERASED = 9'h000;
  localparam logic [8:0]  SLOT_RESET  = 9'h080;
  localparam logic [1:0]  SLOT_ZERO   = 2'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAVE_TIME_NS  = 2000000;
  localparam int SAVE_CYCLES   = SAVE_TIME_NS / CLK_PERIOD_NS;
  localparam int BUSY_W        = 16;

  typedef enum logic [3:0] {
    OP_NOP    = 4'h0,
    OP_WAKE   = 4'h1,
    OP_PROG   = 4'h2,
    OP_STORE  = 4'h3,
    OP_WRTAP  = 4'h4,
    OP_UP     = 4'h7,
    OP_SLEEP  = 4'h8,
    OP_POR    = 4'h9,
    OP_RDSLOT = 4'ha,
    OP_LOAD   = 4'hb,
    OP_RDTAP  = 4'hc,
    OP_ERASE  = 4'hd,
    OP_DOWN   = 4'hf
  } qpcd_op_e;

  typedef enum logic {
    ST_READY = 1'b0,
    ST_BUSY  = 1'b1
  } qpcd_state_e;

endpackage
`default_nettype wire

// ---- design/qpcd_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface qpcd_link_if;
  logic        cmdValid;
  logic [23:0] cmdWord;
  logic [23:0] respWord;

  modport shifter (output cmdValid, output cmdWord, input respWord);
  modport core    (input cmdValid, input cmdWord, output respWord);
endinterface
`default_nettype wire

// ---- design/qpcd_spi_shifter.sv ----
`timescale 1ns/100ps
`default_nettype none
module qpcd_spi_shifter (
  input  wire logic   clk,     // System clock
  input  wire logic   rstn,    // Async reset, active low
  input  wire logic   spiClk,  // Serial clock pin
  input  wire logic   spiCsN,  // Chip select pin, active low
  input  wire logic   spiSdi,  // Serial data in pin
  output logic        spiSdo,  // Serial data out
  qpcd_link_if.shifter link    // Frames to the decoder
);

  logic [2:0]  sclkSync_q, sclkSync_d;
  logic [2:0]  csSync_q, csSync_d;
  logic [1:0]  sdiSync_q, sdiSync_d;
  logic [23:0] inShift_q, inShift_d;
  logic [23:0] outShift_q, outShift_d;
  logic [4:0]  bitCnt_q, bitCnt_d;
  logic        valid_q, valid_d;
  logic        csLow, csFall, csRise, sclkRise, sclkFall;

  // ****************************************
  // Pin sampling and edges
  // ****************************************
  always_comb begin
    sclkSync_d = {sclkSync_q[1:0], spiClk};
    csSync_d   = {csSync_q[1:0], spiCsN};
    sdiSync_d  = {sdiSync_q[0], spiSdi};
    csLow      = ~csSync_q[1];
    csFall     = csSync_q[2] & ~csSync_q[1];
    csRise     = ~csSync_q[2] & csSync_q[1];
    sclkRise   = csLow & sclkSync_q[1] & ~sclkSync_q[2];
    sclkFall   = csLow & ~csFall & ~sclkSync_q[1] & sclkSync_q[2];
  end

  // ****************************************
  // Shift registers
  // ****************************************
  always_comb begin
    inShift_d  = inShift_q;
    outShift_d = outShift_q;
    bitCnt_d   = bitCnt_q;
    valid_d    = 1'b0;
    if (csFall) begin
      bitCnt_d   = '0;
      outShift_d = link.respWord;
    end else if (sclkFall) begin
      outShift_d = {outShift_q[22:0], 1'b0};
    end
    if (sclkRise) begin
      inShift_d = {inShift_q[22:0], sdiSync_q[1]};
      if (bitCnt_q != qpcd_pkg::CNT_MAX) begin
        bitCnt_d = bitCnt_q + 5'h01;
      end
    end
    // Frames with a wrong clock count never reach the decoder
    if (csRise && bitCnt_q == qpcd_pkg::CNT_FRAME) begin
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclkSync_q <= '0;
      csSync_q   <= 3'h7;
      sdiSync_q  <= '0;
      inShift_q  <= '0;
      outShift_q <= '0;
      bitCnt_q   <= '0;
      valid_q    <= 1'b0;
    end else begin
      sclkSync_q <= sclkSync_d;
      csSync_q   <= csSync_d;
      sdiSync_q  <= sdiSync_d;
      inShift_q  <= inShift_d;
      outShift_q <= outShift_d;
      bitCnt_q   <= bitCnt_d;
      valid_q    <= valid_d;
    end
  end

  assign spiSdo        = outShift_q[23];
  assign link.cmdValid = valid_q;
  assign link.cmdWord  = inShift_q;

endmodule
`default_nettype wire

// ---- design/qpcd_command_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
module qpcd_command_decoder #(
  parameter int SAVE_CYCLES = qpcd_pkg::SAVE_CYCLES
) (
  input  wire logic        clk,            // System clock, 20 MHz
  input  wire logic        rstn,           // Async reset, active low
  input  wire logic        spiClk,         // Serial clock from host
  input  wire logic        spiCsN,         // Chip select, active low
  input  wire logic        spiSdi,         // Serial data in
  input  wire logic        writeProtectN,  // Slot write protect, active low
  output logic             spiSdo,         // Serial data out
  output logic             readyBusy,      // High when ready
  output logic             asleep,         // High in sleep state
  output logic [31:0]      tapValues,      // Four tap registers, channel 0 low
  output logic [3:0]       bufferModes     // Buffer mode per channel
);

  // ****************************************
  // Serial front end
  // ****************************************
  qpcd_link_if link ();

  qpcd_spi_shifter u_shifter (
    .clk    (clk),
    .rstn   (rstn),
    .spiClk (spiClk),
    .spiCsN (spiCsN),
    .spiSdi (spiSdi),
    .spiSdo (spiSdo),
    .link   (link.shifter)
  );

  // ****************************************
  // State
  // ****************************************
  // Loads one less so ready stays low for exactly SAVE_CYCLES cycles
  localparam logic [15:0] BUSY_LOAD = 16'(SAVE_CYCLES - 1);

  logic [3:0][7:0]  tap_q, tap_d;
  logic [3:0]       bufMode_q, bufMode_d;
  logic [15:0][8:0] slot_q, slot_d;
  logic             asleep_q, asleep_d;
  logic             bootLoad_q, bootLoad_d;
  logic [23:0]      resp_q, resp_d;
  logic [15:0]      busyCnt_q, busyCnt_d;
  logic             ready_q, ready_d;
  logic [1:0]       wpSync_q, wpSync_d;
  qpcd_pkg::qpcd_state_e state_q, state_d;

  qpcd_pkg::qpcd_op_e op;
  logic [1:0]  chan;
  logic [3:0]  slotIdx;
  logic [8:0]  slotData;
  logic        slotWriteOk;
  logic        slowCmd;

  // ****************************************
  // Field decoding
  // ****************************************
  function automatic logic [3:0] opcodeBits(input logic [23:0] w);
    opcodeBits = w[qpcd_pkg::OPC_LSB +: 4];
  endfunction

  function automatic logic [1:0] fieldOf(input logic [23:0] w, input int lsb);
    fieldOf = w[lsb +: 2];
  endfunction

  function automatic logic [23:0] padData(input logic [8:0] d);
    padData = {15'h0000, d};
  endfunction

  always_comb begin
    op          = qpcd_pkg::qpcd_op_e'(opcodeBits(link.cmdWord));
    chan        = fieldOf(link.cmdWord, qpcd_pkg::CHAN_LSB);
    slotIdx     = {fieldOf(link.cmdWord, qpcd_pkg::SLOT_LSB), chan};
    slotData    = link.cmdWord[qpcd_pkg::DATA_W-1:0];
    slotWriteOk = wpSync_q[1];
    // Reads count as slow too, so the host polls ready alike for all five
    slowCmd     = (op == qpcd_pkg::OP_RDTAP) || (op == qpcd_pkg::OP_RDSLOT) ||
                  (op == qpcd_pkg::OP_PROG) || (op == qpcd_pkg::OP_LOAD) ||
                  (op == qpcd_pkg::OP_STORE);
  end

  // ****************************************
  // Command execution
  // ****************************************
  always_comb begin
    tap_d      = tap_q;
    bufMode_d  = bufMode_q;
    slot_d     = slot_q;
    asleep_d   = asleep_q;
    bootLoad_d = 1'b0;
    resp_d     = resp_q;
    if (bootLoad_q) begin
      for (int c = 0; c < qpcd_pkg::NCHAN; c++) begin
        {bufMode_d[c], tap_d[c]} = slot_q[{qpcd_pkg::SLOT_ZERO, 2'(c)}];
      end
    end else if (link.cmdValid) begin
      // Non-read commands pass through for daisy chaining
      resp_d = link.cmdWord;
      if (asleep_q) begin
        // Asleep, only the wake-up opcode is decoded
        if (op == qpcd_pkg::OP_WAKE) begin
          asleep_d = 1'b0;
        end
      end else begin
        case (op)
          qpcd_pkg::OP_SLEEP: asleep_d = 1'b1;
          qpcd_pkg::OP_POR: begin
            // Slots are kept; only taps and modes reload
            asleep_d   = 1'b1;
            bootLoad_d = 1'b1;
          end
          qpcd_pkg::OP_WRTAP: tap_d[chan] = link.cmdWord[qpcd_pkg::TAP_W-1:0];
          qpcd_pkg::OP_UP: begin
            if (tap_q[chan] != qpcd_pkg::TAP_MAX) begin
              tap_d[chan] = tap_q[chan] + 8'h01;
            end
          end
          qpcd_pkg::OP_DOWN: begin
            if (tap_q[chan] != qpcd_pkg::TAP_MIN) begin
              tap_d[chan] = tap_q[chan] - 8'h01;
            end
          end
          qpcd_pkg::OP_LOAD: {bufMode_d[chan], tap_d[chan]} = slot_q[slotIdx];
          qpcd_pkg::OP_PROG: begin
            if (slotWriteOk) begin
              slot_d[slotIdx] = slotData;
            end
          end
          qpcd_pkg::OP_STORE: begin
            if (slotWriteOk) begin
              slot_d[slotIdx] = {bufMode_q[chan], tap_q[chan]};
            end
          end
          qpcd_pkg::OP_ERASE: begin
            if (slotWriteOk) begin
              slot_d[slotIdx] = qpcd_pkg::SLOT_ERASED;
            end
          end
          qpcd_pkg::OP_RDTAP: resp_d = padData({bufMode_q[chan], tap_q[chan]});
          qpcd_pkg::OP_RDSLOT: resp_d = padData(slot_q[slotIdx]);
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Ready and busy pacing
  // ****************************************
  // Commands that arrive while busy still run; pacing is the host's job
  always_comb begin
    state_d   = state_q;
    busyCnt_d = busyCnt_q;
    case (state_q)
      qpcd_pkg::ST_READY: begin
        if (link.cmdValid && !asleep_q && slowCmd) begin
          state_d   = qpcd_pkg::ST_BUSY;
          busyCnt_d = BUSY_LOAD;
        end
      end
      qpcd_pkg::ST_BUSY: begin
        if (busyCnt_q == '0) begin
          state_d = qpcd_pkg::ST_READY;
        end else begin
          busyCnt_d = busyCnt_q - 16'h0001;
        end
      end
      default: state_d = qpcd_pkg::ST_READY;
    endcase
    ready_d = (state_d == qpcd_pkg::ST_READY);
  end

  // ****************************************
  // Write protect sampling
  // ****************************************
  // Two flops because the pin is asynchronous to clk
  always_comb begin
    wpSync_d = {wpSync_q[0], writeProtectN};
  end

  // ****************************************
  // Registers
  // ****************************************
  // Slots model non-volatile cells; reset gives them a fixed image
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tap_q      <= '0;
      bufMode_q  <= '0;
      slot_q     <= {qpcd_pkg::NSLOT{qpcd_pkg::SLOT_RESET}};
      asleep_q   <= 1'b1;
      bootLoad_q <= 1'b1;
      resp_q     <= '0;
      busyCnt_q  <= '0;
      ready_q    <= 1'b1;
      state_q    <= qpcd_pkg::ST_READY;
      wpSync_q   <= '0; // Protected until the pin has been sampled
    end else begin
      tap_q      <= tap_d;
      bufMode_q  <= bufMode_d;
      slot_q     <= slot_d;
      asleep_q   <= asleep_d;
      bootLoad_q <= bootLoad_d;
      resp_q     <= resp_d;
      busyCnt_q  <= busyCnt_d;
      ready_q    <= ready_d;
      state_q    <= state_d;
      wpSync_q   <= wpSync_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.respWord = resp_q;
  assign readyBusy     = ready_q;
  assign asleep        = asleep_q;
  assign tapValues     = tap_q;
  assign bufferModes   = bufMode_q;

endmodule
`default_nettype wire

// ---- dv/qpcd_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module qpcd_checker #(
  parameter int SAVE_CYCLES = 8
) (
  input wire logic        clk,           // System clock
  input wire logic        rstn,          // Reset, active low
  input wire logic        spiClk,        // Serial clock
  input wire logic        spiCsN,        // Chip select, active low
  input wire logic        spiSdi,        // Serial data in
  input wire logic        writeProtectN, // Slot protect, active low
  input wire logic        spiSdo,        // Serial data out
  input wire logic        readyBusy,     // Ready flag
  input wire logic        asleep,        // Sleep state
  input wire logic [31:0] tapValues,     // Tap registers
  input wire logic [3:0]  bufferModes    // Buffer modes
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // Busy length counter
  // ****************************************
  logic [15:0] busyCnt_q;
  logic [15:0] busyCnt_d;
  always_comb busyCnt_d = readyBusy ? 16'h0 : busyCnt_q + 16'h1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) busyCnt_q <= 16'h0;
    else busyCnt_q <= busyCnt_d;
  end
  // ****************************************
  // Properties
  // ****************************************
  sequence s_reload;
    ##1 asleep && tapValues == 32'h80808080 && bufferModes == 4'h0;
  endsequence
  property p_reload; $rose(rstn) |-> s_reload; endproperty
  // Three samples asleep: the reload after a software reset lands just after sleep begins
  property p_sleep_hold;
    asleep && $past(asleep) && $past(asleep, 2) && $past(rstn, 2) |->
      $stable(tapValues) && $stable(bufferModes);
  endproperty
  property p_mode_load; !$stable(bufferModes) |-> !readyBusy || asleep; endproperty
  property p_sdo_edge;
    $changed(spiSdo) && $past(rstn, 2) |-> !$past(spiClk, 2) || $past(spiCsN, 2);
  endproperty
  property p_busy_cs; $fell(readyBusy) |-> spiCsN; endproperty
  property p_busy_len; $rose(readyBusy) |-> busyCnt_q == 16'(SAVE_CYCLES); endproperty
  property p_busy_cap; busyCnt_q <= 16'(SAVE_CYCLES); endproperty
  property p_wake_cs; $fell(asleep) |-> spiCsN && readyBusy; endproperty
  property p_busy_awake; $fell(readyBusy) |-> !asleep; endproperty
  a_reload: assert property (p_reload) else $error("reset reload wrong");
  a_sleep_hold: assert property (p_sleep_hold) else $error("taps moved asleep");
  a_mode_load: assert property (p_mode_load) else $error("mode changed outside load");
  a_sdo_edge: assert property (p_sdo_edge) else $error("sdo moved with clock high");
  a_busy_cs: assert property (p_busy_cs) else $error("busy inside frame");
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  a_busy_cap: assert property (p_busy_cap) else $error("busy too long");
  a_wake_cs: assert property (p_wake_cs) else $error("wake inside frame");
  a_busy_awake: assert property (p_busy_awake) else $error("busy while asleep");
endmodule
bind qpcd_command_decoder qpcd_checker #(.SAVE_CYCLES(SAVE_CYCLES)) qpcd_checker_inst (
  .clk(clk), .rstn(rstn), .spiClk(spiClk), .spiCsN(spiCsN), .spiSdi(spiSdi),
  .writeProtectN(writeProtectN), .spiSdo(spiSdo), .readyBusy(readyBusy),
  .asleep(asleep), .tapValues(tapValues), .bufferModes(bufferModes));
`default_nettype wire

// ---- dv/qpcd_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module qpcd_host_model (
  input  wire logic clk,       // System clock
  input  wire logic readyBusy, // Device ready
  input  wire logic spiSdo,    // Device serial out
  output logic      spiClk,    // Serial clock
  output logic      spiCsN,    // Chip select, active low
  output logic      spiSdi     // Serial data out of host
);
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiSdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Half period of 4 clocks gives the 400 ns link clock; it stands low between frames
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
    r = 24'h0;
    while (readyBusy !== 1'b1) tick(1);
    spiCsN <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      spiSdi <= (i < 24) ? w[23 - i] : 1'b0;
      tick(4);
      spiClk <= 1'b1;
      r = {r[22:0], spiSdo};
      tick(4);
      spiClk <= 1'b0;
    end
    tick(4);
    spiCsN <= 1'b1;
    // Released data line must not keep the last bit
    spiSdi <= ~spiSdi;
    tick(8);
  endtask
endmodule
`default_nettype wire

// ---- dv/quad_pot_command_decoder_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module quad_pot_command_decoder_bench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wpN = 1'b1;
  logic        spiClk, spiCsN, spiSdi, spiSdo, readyBusy, asleep;
  logic [31:0] tapValues;
  logic [3:0]  bufferModes;
  int          err_total = 0;
  int          num_checks = 0;
  logic [7:0]  tap[4];
  logic        mode[4];
  logic [8:0]  slot[4][4];
  logic        asl = 1'b1;
  logic        known = 1'b0;
  logic [23:0] resp, got, w;
  always #25 clk = ~clk;
  qpcd_command_decoder #(.SAVE_CYCLES(8)) qpcd_command_decoder_inst (
    .clk(clk), .rstn(rstn), .spiClk(spiClk), .spiCsN(spiCsN), .spiSdi(spiSdi),
    .writeProtectN(wpN), .spiSdo(spiSdo), .readyBusy(readyBusy), .asleep(asleep),
    .tapValues(tapValues), .bufferModes(bufferModes));
  qpcd_host_model qpcd_host_model_inst (
    .clk(clk), .readyBusy(readyBusy), .spiSdo(spiSdo),
    .spiClk(spiClk), .spiCsN(spiCsN), .spiSdi(spiSdi));
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  // Expected device state after one well-framed command
  task automatic step(input logic [23:0] c);
    logic [1:0] s, h;
    s = c[19:18];
    h = c[17:16];
    resp = c;
    if (asl) begin
      if (c[23:20] == 4'h1) asl = 1'b0;
    end else begin
      case (c[23:20])
        4'h8: asl = 1'b1;
        4'h9: begin
          asl = 1'b1;
          for (int i = 0; i < 4; i++) {mode[i], tap[i]} = slot[i][0];
        end
        4'h4: tap[h] = c[7:0];
        4'h7: if (tap[h] != 8'hff) tap[h]++;
        4'hf: if (tap[h] != 8'h00) tap[h]--;
        4'hb: {mode[h], tap[h]} = slot[h][s];
        4'h2: if (wpN) slot[h][s] = c[8:0];
        4'h3: if (wpN) slot[h][s] = {mode[h], tap[h]};
        4'hd: if (wpN) slot[h][s] = 9'h000;
        4'hc: resp = {15'h0, mode[h], tap[h]};
        4'ha: resp = {15'h0, slot[h][s]};
        default: ;
      endcase
    end
  endtask
  // Bits the host sees on sdo for an n-clock frame of a standing response
  function automatic logic [23:0] sdoExpect(input logic [23:0] r, input int n);
    if (n <= 24) sdoExpect = r >> (24 - n);
    else sdoExpect = r << (n - 24);
  endfunction
  task automatic cmd(input logic [23:0] c, input int n);
    logic slow;
    slow = !asl && (c[23:20] inside {4'hc, 4'ha, 4'h2, 4'hb, 4'h3});
    qpcd_host_model_inst.xfer(c, n, got);
    if (known) chk(got === sdoExpect(resp, n), "response word");
    if (n == 24) begin
      step(c);
      known = 1'b1;
      @(negedge clk);
      chk(readyBusy === !slow, "ready flag");
    end
    repeat (12) @(posedge clk);
    chk(tapValues === {tap[3], tap[2], tap[1], tap[0]}, "tap values");
    chk(bufferModes === {mode[3], mode[2], mode[1], mode[0]}, "modes");
    chk(asleep === asl, "sleep state");
  endtask
  logic [23:0] corner[17] = '{24'h4000ab, 24'h100000, 24'h4100ff, 24'h710000,
    24'h420000, 24'hf20000, 24'hd70000, 24'h2701a5,
    24'hb70000, 24'hc30000, 24'ha70000,
    24'h000000, 24'h500012, 24'h3b0000, 24'hdb0000, 24'h900000, 24'h100000};
  initial begin
    void'($urandom(15));
    for (int i = 0; i < 4; i++) begin
      tap[i] = 8'h80;
      mode[i] = 1'b0;
      for (int j = 0; j < 4; j++) slot[i][j] = 9'h080;
    end
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (corner[i]) cmd(corner[i], 24);
    cmd(24'h4300cc, 23);
    cmd(24'h4300cc, 25);
    for (int k = 0; k < 48; k++) begin
      w = 24'($urandom);
      if (asl && w[23:20] inside {4'hc, 4'ha}) w[23:20] = 4'h1;
      @(posedge clk);
      wpN <= 1'($urandom);
      if (w[23:20] == 4'h2) cmd({4'hd, w[19:0]}, 24);
      cmd(w, 24);
    end
    conclude();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
